// ---- serial_node.sv ----
// Remote serial node: decodes txd frames and sends frames on rxd
`timescale 1ns/1ps
`default_nettype none
module serial_node
(
    input wire logic clock,
    input wire logic baud_tick,
    input wire logic txd,
    output logic     rxd
);
    logic       nine = 1'b0;
    logic [9:0] got;
    int         frames = 0;
    initial rxd = 1'b1;
    task automatic ticks(input int n);
        repeat (n) @(posedge clock iff baud_tick);
    endtask
    // Sample each txd bit at its centre, 16 ticks apart
    initial forever
    begin
        @(negedge txd);
        ticks(8);
        for (int i = 0; i < 9 + nine; i++)
        begin
            ticks(16);
            got[i] = txd;
        end
        frames++;
    end
    // A low stop is cut short so the line is idle before a false start confirms
    task automatic send(input logic [9:0] bits, input int n);
        for (int i = -1; i < n; i++)
        begin
            rxd <= (i < 0) ? 1'b0 : bits[i];
            ticks((i == n - 1 && !bits[i]) ? 12 : 16);
        end
        rxd <= 1'b1;
    endtask
endmodule // serial_node
`default_nettype wire

// ---- serial_port.sv ----
// Nine-bit asynchronous serial port with control and data buffer registers
//
// Functional notes
// RQ1 - Mode bit picks 8-bit or 9-bit frames
// RQ2 - Control bit 6 reads one, writes ignored
// RQ3 - 8-bit qualify: flag only on high stop
// RQ4 - 9-bit qualify: flag only on ninth one
// RQ5 - Receive only while receive enable set
// RQ6 - 9-bit mode sends tx_ninth_bit as ninth
// RQ7 - rx_ninth_bit gets stop or ninth bit
// RQ8 - tx_done_flag set at end of data bits
// RQ9 - rx_done_flag set at stop bit sample
// RQ10 - Interrupt when flag set and enabled
// RQ11 - Software alone clears both done flags
// RQ12 - Data write loads and starts transmission; code queues it in a two-entry buffer and drops it when both entries are full
// RQ13 - Data read returns receive latch only
// RQ14 - Low start, LSB first, ninth, high stop
// RQ15 - Bits timed by external 16x baud tick
`timescale 1ns/1ps
`include "serial_port_defs.svh"
`default_nettype none

module serial_port
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic       irq_enable,
    input  wire logic       baud_tick,
    input  wire logic       rxd,
    output logic            txd,
    output logic            irq,
    output logic            tx_buf_ready
);

    serial_port_pkg::state_type s_r;
    serial_port_pkg::state_type s_nxt;

    // Index of the last data bit for the current frame length
    function automatic logic [3:0] last_bit(input logic nine);
        last_bit = nine ? `SP_LAST_BIT_9 : `SP_LAST_BIT_8; // RQ1
    endfunction

    // Control register image as software sees it
    function automatic logic [7:0] ctl_image(input serial_port_pkg::state_type st);
        ctl_image = {st.mode, 1'b1, st.qual, st.ren, st.tb8, st.rb8, st.ti, st.ri}; // RQ2
    endfunction

    logic       ctl_wr;
    logic       data_wr;
    logic       push;
    logic       pop;
    logic [7:0] rx_byte;
    logic       rx_ninth;

    // Access decode
    assign ctl_wr  = wr_en && (addr == `SP_CTL_ADDR);
    assign data_wr = wr_en && (addr == `SP_DATA_ADDR);
    // A write while both entries are full is dropped; tx_buf_ready warns first
    assign push    = data_wr && (s_r.fifo_cnt != 2'h2);
    assign pop     = (s_r.tx_state == serial_port_pkg::TX_IDLE) && (s_r.fifo_cnt != 2'h0);

    // Alignment of received bits depends on how many were shifted in
    assign rx_byte  = s_r.mode ? s_r.rx_shift[7:0] : s_r.rx_shift[8:1];
    assign rx_ninth = s_r.mode ? s_r.rx_shift[8] : rxd; // RQ7

    // Next-state logic for the whole port
    always_comb
    begin
        s_nxt = s_r;

        // Software write to control; bit 6 has no storage
        if (ctl_wr)
        begin
            s_nxt.mode = wdata[`SP_BIT_MODE]; // RQ1
            s_nxt.qual = wdata[`SP_BIT_QUAL];
            s_nxt.ren  = wdata[`SP_BIT_REN];
            s_nxt.tb8  = wdata[`SP_BIT_TB8];
            s_nxt.rb8  = wdata[`SP_BIT_RB8];
            s_nxt.ti   = wdata[`SP_BIT_TI]; // RQ11
            s_nxt.ri   = wdata[`SP_BIT_RI]; // RQ11
        end

        // Two-entry transmit buffer so two back-to-back writes are kept while a frame is sent
        if (push)
        begin
            s_nxt.fifo_mem[s_r.fifo_wp] = wdata; // RQ12
            s_nxt.fifo_wp = ~s_r.fifo_wp;
        end
        if (pop)
        begin
            s_nxt.fifo_rp = ~s_r.fifo_rp;
        end
        if (push && !pop)
        begin
            s_nxt.fifo_cnt = s_r.fifo_cnt + 2'h1;
        end
        else if (pop && !push)
        begin
            s_nxt.fifo_cnt = s_r.fifo_cnt - 2'h1;
        end

        // Transmitter
        if (pop)
        begin
            // Ninth bit sits above the byte; only shifted out in 9-bit mode
            s_nxt.tx_shift = {s_r.tb8, s_r.fifo_mem[s_r.fifo_rp]}; // RQ6
            s_nxt.tx_bits  = last_bit(s_r.mode);
            s_nxt.tx_tick  = 4'h0;
            s_nxt.tx_state = serial_port_pkg::TX_START;
            s_nxt.txd      = 1'b0; // RQ14
        end
        else if (baud_tick && (s_r.tx_state != serial_port_pkg::TX_IDLE))
        begin
            s_nxt.tx_tick = s_r.tx_tick + 4'h1; // RQ15
            if (s_r.tx_tick == `SP_TICK_LAST)
            begin
                case (s_r.tx_state)
                    serial_port_pkg::TX_START:
                    begin
                        s_nxt.tx_state = serial_port_pkg::TX_DATA;
                        s_nxt.txd      = s_r.tx_shift[0]; // RQ14
                        s_nxt.tx_shift = {1'b0, s_r.tx_shift[8:1]};
                    end
                    serial_port_pkg::TX_DATA:
                    begin
                        if (s_r.tx_bits == 4'h0)
                        begin
                            s_nxt.tx_state = serial_port_pkg::TX_STOP;
                            s_nxt.txd      = 1'b1; // RQ14
                            s_nxt.ti       = 1'b1; // RQ8
                        end
                        else
                        begin
                            s_nxt.txd      = s_r.tx_shift[0];
                            s_nxt.tx_shift = {1'b0, s_r.tx_shift[8:1]};
                            s_nxt.tx_bits  = s_r.tx_bits - 4'h1;
                        end
                    end
                    default:
                    begin
                        s_nxt.tx_state = serial_port_pkg::TX_IDLE;
                    end
                endcase
            end
        end

        // Receiver; clearing the enable abandons a frame in progress
        if (!s_r.ren)
        begin
            s_nxt.rx_state = serial_port_pkg::RX_IDLE; // RQ5
        end
        else if (s_r.rx_state == serial_port_pkg::RX_IDLE)
        begin
            if (!rxd)
            begin
                s_nxt.rx_state = serial_port_pkg::RX_START; // RQ5
                s_nxt.rx_tick  = 4'h0;
            end
        end
        else if (baud_tick)
        begin
            s_nxt.rx_tick = s_r.rx_tick + 4'h1; // RQ15
            case (s_r.rx_state)
                serial_port_pkg::RX_START:
                begin
                    // Recheck at mid start bit to reject glitches
                    if (s_r.rx_tick == `SP_TICK_MID)
                    begin
                        s_nxt.rx_tick  = 4'h0;
                        s_nxt.rx_bits  = last_bit(s_r.mode);
                        s_nxt.rx_state = rxd ? serial_port_pkg::RX_IDLE
                                             : serial_port_pkg::RX_DATA;
                    end
                end
                serial_port_pkg::RX_DATA:
                begin
                    if (s_r.rx_tick == `SP_TICK_LAST)
                    begin
                        s_nxt.rx_shift = {rxd, s_r.rx_shift[8:1]}; // RQ14
                        if (s_r.rx_bits == 4'h0)
                        begin
                            s_nxt.rx_state = serial_port_pkg::RX_STOP;
                        end
                        else
                        begin
                            s_nxt.rx_bits = s_r.rx_bits - 4'h1;
                        end
                    end
                end
                default:
                begin
                    if (s_r.rx_tick == `SP_TICK_LAST)
                    begin
                        s_nxt.rx_state = serial_port_pkg::RX_IDLE;
                        // Qualifier drops the frame without touching latch
                        if (!s_r.qual || rx_ninth) // RQ3 RQ4
                        begin
                            s_nxt.rx_latch = rx_byte;
                            s_nxt.rb8      = rx_ninth; // RQ7
                            s_nxt.ri       = 1'b1; // RQ9
                        end
                    end
                end
            endcase
        end

        // Read data is registered; it appears the cycle after the strobe
        if (rd_en)
        begin
            if (addr == `SP_CTL_ADDR)
            begin
                s_nxt.rdata = ctl_image(s_nxt); // RQ2
            end
            else if (addr == `SP_DATA_ADDR)
            begin
                s_nxt.rdata = s_r.rx_latch; // RQ13
            end
            else
            begin
                s_nxt.rdata = `SP_UNMAPPED_READ;
            end
        end

        // Status outputs follow the updated flags
        s_nxt.irq        = irq_enable && (s_nxt.ti || s_nxt.ri); // RQ10
        s_nxt.fifo_ready = (s_nxt.fifo_cnt != 2'h2);
    end

    // State register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r            <= '0;
            s_r.rdata      <= `SP_DATA_RESET;
            s_r.tx_state   <= serial_port_pkg::TX_IDLE;
            s_r.rx_state   <= serial_port_pkg::RX_IDLE;
            s_r.txd        <= 1'b1;
            s_r.fifo_ready <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign rdata        = s_r.rdata;
    assign txd          = s_r.txd;
    assign irq          = s_r.irq;
    assign tx_buf_ready = s_r.fifo_ready;

endmodule // serial_port

`default_nettype wire

// ---- serial_port_asserts.sv ----
// Port-level assertions for the nine-bit serial port
`timescale 1ns/1ps
`include "serial_port_defs.svh"
`default_nettype none
module serial_port_asserts
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] addr,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       irq_enable,
    input wire logic       baud_tick,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic       irq,
    input wire logic       tx_buf_ready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Decoded accesses
    wire ctl_rd = rd_en && addr == `SP_CTL_ADDR;
    wire ctl_wr = wr_en && addr == `SP_CTL_ADDR;
    wire odd_rd = rd_en && addr != `SP_CTL_ADDR && addr != `SP_DATA_ADDR;
    a_bit6_one: assert property (ctl_rd |=> rdata[6])
        else $error("control bit six read low");
    a_unmapped_zero: assert property (odd_rd |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
        else $error("read data moved without read");
    a_ctl_readback: assert property ((ctl_wr && !rd_en) ##1 (ctl_rd && !wr_en) |=>
        rdata[7:3] == {$past(wdata[7], 2), 1'b1, $past(wdata[5:3], 2)})
        else $error("control readback wrong");
    a_irq_gated: assert property (!irq_enable |=> !irq)
        else $error("interrupt while disabled");
    // Flags stay until software writes, so a pending irq shows a flag
    a_irq_has_flag: assert property (irq && ctl_rd && !wr_en && !$past(wr_en) |=>
        rdata[1:0] != 2'h0)
        else $error("interrupt without flag");
    a_ready_holds: assert property
        (tx_buf_ready && !(wr_en && addr == `SP_DATA_ADDR) |=> tx_buf_ready)
        else $error("buffer filled without write");
    a_txd_tick: assert property ($rose(txd) |-> $past(baud_tick))
        else $error("txd rose off a baud tick");
    c_full: cover property (!tx_buf_ready);
    c_irq: cover property ($rose(irq));
    c_tx: cover property ($fell(txd));
    c_rx: cover property ($fell(rxd));
endmodule // serial_port_asserts
bind serial_port serial_port_asserts serial_port_asserts_inst (.clock, .rst_n, .addr,
    .wr_en, .rd_en, .wdata, .rdata, .irq_enable, .baud_tick, .rxd, .txd, .irq,
    .tx_buf_ready);
`default_nettype wire

// ---- serial_port_defs.svh ----
// Register addresses, field positions, reset values and bit timing counts
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define SP_CTL_ADDR       8'h98
`define SP_DATA_ADDR      8'h99
`define SP_CTL_RESET      8'h40
`define SP_DATA_RESET     8'h00
`define SP_UNMAPPED_READ  8'h00

`define SP_BIT_MODE       7
`define SP_BIT_UNUSED     6
`define SP_BIT_QUAL       5
`define SP_BIT_REN        4
`define SP_BIT_TB8        3
`define SP_BIT_RB8        2
`define SP_BIT_TI         1
`define SP_BIT_RI         0

// Baud ticks per bit is 16; last tick of a bit and the bit centre
`define SP_TICK_LAST      4'hF
`define SP_TICK_MID       4'h7
`define SP_LAST_BIT_8     4'h7
`define SP_LAST_BIT_9     4'h8

`endif

// ---- serial_port_pkg.sv ----
// Types shared by the nine-bit serial port
`default_nettype none
package serial_port_pkg;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

    typedef struct packed {
        logic              mode;
        logic              qual;
        logic              ren;
        logic              tb8;
        logic              rb8;
        logic              ti;
        logic              ri;
        logic [7:0]        rx_latch;
        logic [7:0]        rdata;
        logic              irq;
        logic [1:0][7:0]   fifo_mem;
        logic              fifo_wp;
        logic              fifo_rp;
        logic [1:0]        fifo_cnt;
        logic              fifo_ready;
        tx_state_type      tx_state;
        logic [8:0]        tx_shift;
        logic [3:0]        tx_bits;
        logic [3:0]        tx_tick;
        logic              txd;
        rx_state_type      rx_state;
        logic [8:0]        rx_shift;
        logic [3:0]        rx_bits;
        logic [3:0]        rx_tick;
    } state_type;

endpackage

`default_nettype wire

// ---- serial_port_tb.sv ----
// Self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
`include "serial_port_defs.svh"
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module serial_port_tb;
    logic       clock = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic       irq_enable = 1'b0, baud_tick = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rd_val;
    wire        rxd, txd, irq, tx_buf_ready;
    wire  [7:0] rdata;
    int         n_errors = 0, n_checks = 0, base;
    // Clock and a baud tick every second cycle
    always #50 clock = ~clock;
    always @(posedge clock) baud_tick <= ~baud_tick;
    serial_port serial_port_inst (.clock, .rst_n, .addr, .wr_en, .rd_en, .wdata, .rdata,
        .irq_enable, .baud_tick, .rxd, .txd, .irq, .tx_buf_ready);
    serial_node serial_node_inst (.clock, .baud_tick, .txd, .rxd);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 rd_val = rdata;
    endtask
    // One frame is at most 11 bits of 32 cycles
    task automatic fw(input int n);
        repeat (n * 360) @(posedge clock);
        #1;
    endtask
    task automatic t_regs;
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'h40)
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'h00)
        rd(8'h9A);
        `CHK(rd_val, 8'h00)
        wr(`SP_CTL_ADDR, 8'hB8);
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'hF8)
        // Write then read on consecutive edges; the read shows the new value
        @(posedge clock);
        addr <= `SP_CTL_ADDR;
        wdata <= 8'h28;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 `CHK(rdata, 8'h68)
        $display("regs done");
    endtask
    task automatic t_tx8;
        wr(`SP_CTL_ADDR, 8'h00);
        irq_enable <= 1'b1;
        wr(`SP_DATA_ADDR, 8'hA5);
        fw(1);
        `CHK(serial_node_inst.got[8:0], 9'h1A5)
        `CHK(irq, 1'b1)
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'h42)
        @(posedge clock);
        irq_enable <= 1'b0;
        repeat (2) @(posedge clock);
        #1 `CHK(irq, 1'b0)
        @(posedge clock);
        irq_enable <= 1'b1;
        wr(`SP_CTL_ADDR, 8'h00);
        repeat (2) @(posedge clock);
        #1 `CHK(irq, 1'b0)
        $display("tx8 done");
    endtask
    task automatic t_tx9;
        wr(`SP_CTL_ADDR, 8'h88);
        serial_node_inst.nine = 1'b1;
        base = serial_node_inst.frames;
        @(posedge clock);
        // Five writes back to back overrun the two-entry buffer
        for (int i = 0; i < 5; i++)
        begin
            addr <= `SP_DATA_ADDR;
            wdata <= 8'h3C;
            wr_en <= 1'b1;
            @(posedge clock);
        end
        wr_en <= 1'b0;
        #1 `CHK(tx_buf_ready, 1'b0)
        fw(4);
        `CHK(serial_node_inst.frames - base, 3)
        `CHK(serial_node_inst.got, 10'h33C)
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'hCA)
        $display("tx9 done");
    endtask
    task automatic t_rx;
        wr(`SP_CTL_ADDR, 8'h10);
        serial_node_inst.send(10'h15A, 9);
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'h5A)
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'h55)
        wr(`SP_CTL_ADDR, 8'h30);
        serial_node_inst.send(10'h0C3, 9);
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'h5A)
        wr(`SP_CTL_ADDR, 8'h00);
        serial_node_inst.send(10'h177, 9);
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'h5A)
        wr(`SP_CTL_ADDR, 8'hB0);
        serial_node_inst.send(10'h296, 10);
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'h5A)
        serial_node_inst.send(10'h396, 10);
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'hF5)
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'h96)
        // Without qualify a low stop or ninth bit is kept and overwrites rx_ninth_bit
        wr(`SP_CTL_ADDR, 8'h14);
        serial_node_inst.send(10'h0C3, 9);
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'hC3)
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'h51)
        // Let the false start from the short low stop fall back to idle
        repeat (40) @(posedge clock);
        wr(`SP_CTL_ADDR, 8'h94);
        serial_node_inst.send(10'h296, 10);
        rd(`SP_DATA_ADDR);
        `CHK(rd_val, 8'h96)
        rd(`SP_CTL_ADDR);
        `CHK(rd_val, 8'hD1)
        $display("rx done");
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence after five reset cycles
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_regs;
        t_tx8;
        t_tx9;
        t_rx;
        stop_test;
    end
    // Watchdog, well past the roughly 4200 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        stop_test;
    end
endmodule // serial_port_tb
`default_nettype wire
